/* File: logic/rx_ring_store.sv */
// small byte store for the four ring receive buffers
// assumes one writer and one reader on sys_clk; read data is registered
`timescale 1ns/1ns
`default_nettype none
module rx_ring_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  // contents are undefined after reset, so no reset here
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule : rx_ring_store
`default_nettype wire

/* File: logic/serial_rx_ring_status_irq.sv */
// receive ring status, buffer counter and ring interrupt control
// assumes a receive engine on sys_clk giving one done pulse per frame,
// and the main status register outside holding buffer zero's ready flag
`timescale 1ns/1ns
`default_nettype none
module serial_rx_ring_status_irq
  import rx_ring_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic soft_reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rx_ring_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [rx_ring_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [rx_ring_pkg::DATA_W-1:0] wb_dat_i,
  output logic [rx_ring_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_done,
  input wire rx_ring_pkg::rx_frame_type rx_frame,
  input wire logic buf0_ready_flag,
  input wire logic buf0_ready_irq_enable,
  output logic [7:0] receive_control_reg,
  output logic [1:0] next_buffer_index,
  output logic buf0_fill_strobe,
  output logic rx_irq
);
  import rx_ring_pkg::*;

  // ==========================================================================
  // bus decode
  logic access;
  logic wr;
  logic rd;
  logic [4:0] buf_off;
  logic [1:0] rd_buf;
  logic [7:0] wbyte;
  logic [7:0] store_q;

  wb_access_phase u_phase (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .access(access),
    .wb_ack_o(wb_ack_o)
  );

  // only the low byte lane carries register bits
  assign wr = access && wb_we_i && wb_sel_i[0];
  assign rd = access && !wb_we_i;
  assign wbyte = wb_dat_i[7:0];
  // buffer words sit one word apart above the first buffer offset
  assign buf_off = wb_adr_i - OFF_RX_BUF0;
  assign rd_buf = buf_off[3:2];

  logic wr_status;
  logic wr_irqctl;
  logic wr_rxctl;
  logic rd_buf3;
  assign wr_status = wr && (wb_adr_i == OFF_BUF3_STATUS);
  assign wr_irqctl = wr && (wb_adr_i == OFF_IRQ_CONTROL);
  assign wr_rxctl = wr && (wb_adr_i == OFF_RX_CONTROL);
  assign rd_buf3 = rd && (wb_adr_i == OFF_RX_BUF3);

  // ==========================================================================
  // reception decode
  logic ring_on;
  logic mp_mode;
  logic addr_sel;
  logic rx_ignored;
  logic rx_take;
  logic [1:0] count;
  buffer_sel_type target;
  logic expected_parity;
  logic parity_bad;
  logic marker_bad;
  logic into_buf3;
  logic buf3_unread;

  assign ring_on = receive_control_reg[RING_SEL_BIT];
  assign mp_mode = receive_control_reg[MP_MODE_BIT];
  assign addr_sel = receive_control_reg[ADDR_SEL_BIT];
  // address-only listening drops data frames without touching any buffer
  assign rx_ignored = mp_mode && addr_sel && !rx_frame.frame_address_marker_bit;
  assign rx_take = rx_done && !rx_ignored;
  assign target = ring_on ? buffer_sel_type'(count) : BUF_ZERO;
  assign expected_parity = receive_control_reg[PAR_EVEN_BIT] ?
                           (^rx_frame.data) : ~(^rx_frame.data);
  assign parity_bad = receive_control_reg[PAR_EN_BIT] &&
                      (expected_parity != rx_frame.parity_bit);
  assign marker_bad = mp_mode && !addr_sel &&
                      rx_frame.frame_address_marker_bit;
  assign into_buf3 = rx_take && ring_on && (target == BUF_THREE);

  // ==========================================================================
  // receive control
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      receive_control_reg <= RX_CONTROL_RESET;
    end else if (soft_reset) begin
      receive_control_reg <= RX_CONTROL_RESET;
    end else if (wr_rxctl) begin
      receive_control_reg <= wbyte;
    end
  end

  // ==========================================================================
  // buffer counter
  // the index port mirrors count so the engine needs no status read
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= BUF_ZERO;
    end else if (soft_reset || !ring_on) begin
      count <= BUF_ZERO;
    end else if (rx_take) begin
      count <= count + 2'b01;
    end
  end
  // status writes never reach count, so the monitor bits stay read-only

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      next_buffer_index <= BUF_ZERO;
    end else if (soft_reset || !ring_on) begin
      next_buffer_index <= BUF_ZERO;
    end else if (rx_take) begin
      next_buffer_index <= count + 2'b01;
    end
  end

  // ==========================================================================
  // buffer store, fed regardless of pending flags
  rx_ring_store #(
    .WIDTH(BYTE_W),
    .DEPTH(RING_DEPTH),
    .AW($clog2(RING_DEPTH))
  ) u_store (
    .sys_clk(sys_clk),
    .wr_en(rx_take),
    .wr_addr(target),
    .wr_data(rx_frame.data),
    .rd_addr(rd_buf),
    .rd_data(store_q)
  );

  // ==========================================================================
  // buffer-three error flags
  logic ovr_flag;
  logic par_flag;
  logic mpe_flag;

  // hardware set wins over a same-cycle software clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      buf3_unread <= 1'b0;
    end else if (soft_reset) begin
      buf3_unread <= 1'b0;
    end else if (into_buf3) begin
      buf3_unread <= 1'b1;
    end else if (rd_buf3) begin
      buf3_unread <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ovr_flag <= BUF3_STATUS_RESET[OVR_BIT];
      par_flag <= BUF3_STATUS_RESET[PAR_BIT];
      mpe_flag <= BUF3_STATUS_RESET[MPE_BIT];
    end else if (soft_reset) begin
      ovr_flag <= BUF3_STATUS_RESET[OVR_BIT];
      par_flag <= BUF3_STATUS_RESET[PAR_BIT];
      mpe_flag <= BUF3_STATUS_RESET[MPE_BIT];
    end else begin
      ovr_flag <= (wr_status ? wbyte[OVR_BIT] : ovr_flag) |
                  (into_buf3 && buf3_unread);
      par_flag <= (wr_status ? wbyte[PAR_BIT] : par_flag) |
                  (into_buf3 && parity_bad);
      mpe_flag <= (wr_status ? wbyte[MPE_BIT] : mpe_flag) |
                  (into_buf3 && marker_bad);
    end
  end

  // ==========================================================================
  // per-buffer ready flags and enables for buffers one to three
  logic [3:1] ready;
  logic [3:1] enable;

  for (genvar gi = 1; gi <= 3; gi++) begin : g_buf
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        enable[gi] <= IRQ_CONTROL_RESET[IE_LO_BIT + gi - 1];
      end else if (soft_reset) begin
        enable[gi] <= IRQ_CONTROL_RESET[IE_LO_BIT + gi - 1];
      end else if (wr_irqctl) begin
        enable[gi] <= wbyte[IE_LO_BIT + gi - 1];
      end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        ready[gi] <= IRQ_CONTROL_RESET[RDY_LO_BIT + gi - 1];
      end else if (soft_reset) begin
        ready[gi] <= IRQ_CONTROL_RESET[RDY_LO_BIT + gi - 1];
      end else begin
        // only a write or a reset clears; servicing the request does not
        ready[gi] <= (wr_irqctl ? wbyte[RDY_LO_BIT + gi - 1] : ready[gi]) |
                     (rx_take && ring_on && (target == 2'(gi)));
      end
    end
  end

  // ==========================================================================
  // buffer zero hand-off and combined request
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      buf0_fill_strobe <= 1'b0;
    end else begin
      buf0_fill_strobe <= rx_take && (target == BUF_ZERO) && !soft_reset;
    end
  end

  // ring enables are meaningless outside ring mode
  // a soft reset drops the request at once, not one cycle late
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_irq <= 1'b0;
    end else if (soft_reset) begin
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= (buf0_ready_flag && buf0_ready_irq_enable) ||
                (ring_on && |(ready & enable));
    end
  end

  // ==========================================================================
  // read data
  logic [7:0] status_view;
  logic [7:0] irqctl_view;
  logic [7:0] rd_byte;

  always_comb begin
    status_view = BUF3_STATUS_UNUSED;
    status_view[OVR_BIT] = ovr_flag;
    status_view[PAR_BIT] = par_flag;
    status_view[MPE_BIT] = mpe_flag;
    status_view[CNT_LO_BIT] = count[0];
    status_view[CNT_HI_BIT] = count[1];
  end

  always_comb begin
    irqctl_view = IRQ_CONTROL_UNUSED;
    irqctl_view[IE_LO_BIT +: 3] = enable;
    irqctl_view[RDY0_BIT] = buf0_ready_flag;
    irqctl_view[RDY_LO_BIT +: 3] = ready;
  end

  always_comb begin
    if (wb_adr_i == OFF_BUF3_STATUS) begin
      rd_byte = status_view;
    end else if (wb_adr_i == OFF_IRQ_CONTROL) begin
      rd_byte = irqctl_view;
    end else if (wb_adr_i == OFF_RX_CONTROL) begin
      rd_byte = receive_control_reg;
    end else if (wb_adr_i == OFF_RX_BUF0 || wb_adr_i == OFF_RX_BUF1 ||
                 wb_adr_i == OFF_RX_BUF2 || wb_adr_i == OFF_RX_BUF3) begin
      rd_byte = store_q;
    end else begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= '0;
    end else if (rd) begin
      wb_dat_o <= {{(DATA_W - BYTE_W){1'b0}}, rd_byte};
    end
  end

endmodule : serial_rx_ring_status_irq
`default_nettype wire

/* File: logic/wb_access_phase.sv */
// classic wishbone handshake sequencer: one access pulse, then ack
// assumes the master holds its request until it samples ack
`timescale 1ns/1ns
`default_nettype none
module wb_access_phase
  import rx_ring_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic access,
  output logic wb_ack_o
);

  bus_phase_type phase;
  bus_phase_type next_phase;

  always_comb begin
    next_phase = phase;
    case (phase)
      PHASE_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          next_phase = PHASE_ACCESS;
        end
      end
      PHASE_ACCESS: begin
        next_phase = PHASE_ANSWER;
      end
      PHASE_ANSWER: begin
        next_phase = PHASE_RELEASE;
      end
      // the request is still seen high at the edge that takes ack
      PHASE_RELEASE: begin
        if (!(wb_cyc_i && wb_stb_i)) begin
          next_phase = PHASE_IDLE;
        end
      end
      default: begin
        next_phase = PHASE_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= PHASE_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= (next_phase == PHASE_ANSWER);
    end
  end

  assign access = (phase == PHASE_ACCESS);

endmodule : wb_access_phase
`default_nettype wire

/* File: pkg/rx_ring_pkg.sv */
// constants, field positions and carrier types of the receive ring status block
// assumes a 32-bit classic wishbone register port and a receive engine on sys_clk
package rx_ring_pkg;

  // ==========================================================================
  // register map, byte addresses of aligned words
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;
  localparam logic [4:0] OFF_BUF3_STATUS = 5'h00;
  localparam logic [4:0] OFF_IRQ_CONTROL = 5'h04;
  localparam logic [4:0] OFF_RX_CONTROL = 5'h08;
  localparam logic [4:0] OFF_RX_BUF0 = 5'h0c;
  localparam logic [4:0] OFF_RX_BUF1 = 5'h10;
  localparam logic [4:0] OFF_RX_BUF2 = 5'h14;
  localparam logic [4:0] OFF_RX_BUF3 = 5'h18;

  // ==========================================================================
  // buffer-three status fields
  localparam int OVR_BIT = 1;
  localparam int PAR_BIT = 2;
  localparam int MPE_BIT = 3;
  localparam int CNT_LO_BIT = 4;
  localparam int CNT_HI_BIT = 5;
  localparam logic [7:0] BUF3_STATUS_RESET = 8'hc1;
  localparam logic [7:0] BUF3_STATUS_UNUSED = 8'hc1;

  // ==========================================================================
  // ring interrupt control fields
  localparam int IE_LO_BIT = 1;
  localparam int RDY0_BIT = 4;
  localparam int RDY_LO_BIT = 5;
  localparam logic [7:0] IRQ_CONTROL_RESET = 8'h01;
  localparam logic [7:0] IRQ_CONTROL_UNUSED = 8'h01;

  // ==========================================================================
  // receive control fields
  localparam int MP_MODE_BIT = 0;
  localparam int ADDR_SEL_BIT = 2;
  localparam int RING_SEL_BIT = 3;
  localparam int PAR_EN_BIT = 5;
  localparam int PAR_EVEN_BIT = 6;
  localparam logic [7:0] RX_CONTROL_RESET = 8'h00;

  localparam int BYTE_W = 8;
  localparam int RING_DEPTH = 4;

  typedef enum logic [1:0] {
    BUF_ZERO = 2'b00,
    BUF_ONE = 2'b01,
    BUF_TWO = 2'b10,
    BUF_THREE = 2'b11
  } buffer_sel_type;

  typedef enum logic [1:0] {
    PHASE_IDLE = 2'b00,
    PHASE_ACCESS = 2'b01,
    PHASE_ANSWER = 2'b10,
    PHASE_RELEASE = 2'b11
  } bus_phase_type;

  typedef struct packed {
    logic [7:0] data;
    logic parity_bit;
    logic frame_address_marker_bit;
  } rx_frame_type;

endpackage : rx_ring_pkg

/* File: test/rx_engine_model.sv */
// stand-in for the receive shift engine: one done strobe per frame
// assumes sys_clk is shared with the status block
`timescale 1ns/1ns
`default_nettype none
module rx_engine_model
  import rx_ring_pkg::*;
(
  input wire logic sys_clk,
  output logic rx_done,
  output rx_ring_pkg::rx_frame_type rx_frame
);
  initial begin
    rx_done = 1'b0;
    rx_frame = '0;
  end

  // ==========================================================================
  // frame hand-over
  // gap zero keeps the strobe high for back-to-back frames
  task automatic send(input logic [7:0] d, input logic p, input logic m,
      input int gap);
    if (gap > 0) begin
      idle();
      repeat (gap - 1) @(posedge sys_clk);
    end
    rx_done <= 1'b1;
    rx_frame <= '{data: d, parity_bit: p, frame_address_marker_bit: m};
    @(posedge sys_clk);
  endtask : send

  // frame is only valid with the strobe, so scramble it afterwards
  task automatic idle();
    rx_done <= 1'b0;
    rx_frame <= ~rx_frame;
    @(posedge sys_clk);
  endtask : idle
endmodule : rx_engine_model
`default_nettype wire

/* File: test/serial_rx_ring_status_irq_bench.sv */
// self-checking bench: wishbone register calls and receive frames
// assumes the engine model and the bound port monitor
`timescale 1ns/1ns
`default_nettype none
module serial_rx_ring_status_irq_bench;
  import rx_ring_pkg::*;
  logic sys_clk, rst_b, soft_reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADDR_W-1:0] wb_adr_i;
  logic [SEL_W-1:0] wb_sel_i;
  logic [DATA_W-1:0] wb_dat_i, wb_dat_o;
  logic rx_done, buf0_ready_flag, buf0_ready_irq_enable, buf0_fill_strobe;
  logic rx_irq;
  rx_frame_type rx_frame;
  logic [7:0] receive_control_reg, q, ctrl, irqc;
  logic [1:0] next_buffer_index, cnt;
  int miscompares, tests_run;

  serial_rx_ring_status_irq u_serial_rx_ring_status_irq (.sys_clk(sys_clk),
    .rst_b(rst_b), .soft_reset(soft_reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_done(rx_done), .rx_frame(rx_frame),
    .buf0_ready_flag(buf0_ready_flag),
    .buf0_ready_irq_enable(buf0_ready_irq_enable),
    .receive_control_reg(receive_control_reg),
    .next_buffer_index(next_buffer_index),
    .buf0_fill_strobe(buf0_fill_strobe), .rx_irq(rx_irq));
  rx_engine_model u_rx_engine_model (.sys_clk(sys_clk), .rx_done(rx_done),
    .rx_frame(rx_frame));

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  // ==========================================================================
  // access and compare tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    @(posedge sys_clk);
    // only the watchdog ends a wait for the answer
    while (wb_ack_o !== 1'b1) begin
      @(posedge sys_clk);
    end
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    bus(a, 1'b0, 8'h00);
    check(q, exp);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    if (a == OFF_RX_CONTROL) ctrl = d;
    if (a == OFF_IRQ_CONTROL) irqc = d & 8'hef | 8'h01;
    bus(a, 1'b1, d);
  endtask : wr

  // expected counter and ready flags follow each frame
  task automatic rx(input logic [7:0] d, input logic bad, input logic m,
      input int gap);
    u_rx_engine_model.send(d, ^d ^ bad, m, gap);
    if (ctrl[3] && !(ctrl[0] && ctrl[2] && !m)) begin
      if (cnt != 2'b00) irqc = irqc | (8'h10 << cnt);
      cnt = cnt + 2'h1;
    end
  endtask : rx

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    summarize();
  end

  // ==========================================================================
  // main sequence
  initial begin
    {rst_b, soft_reset, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h0;
    {buf0_ready_flag, buf0_ready_irq_enable} = 2'b00;
    wb_adr_i = '0;
    wb_dat_i = '0;
    wb_sel_i = 4'h1;
    {miscompares, tests_run} = '0;
    {ctrl, irqc, cnt} = {8'h00, 8'h01, 2'b00};
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(OFF_BUF3_STATUS, 8'hc1);
    rd(OFF_IRQ_CONTROL, 8'h01);
    rd(OFF_RX_CONTROL, 8'h00);
    rd(5'h1c, 8'h00);
    wr(OFF_BUF3_STATUS, 8'hff);
    rd(OFF_BUF3_STATUS, 8'hcf);
    wr(OFF_BUF3_STATUS, 8'h00);
    rd(OFF_BUF3_STATUS, 8'hc1);
    wr(OFF_IRQ_CONTROL, 8'hff);
    rd(OFF_IRQ_CONTROL, 8'hef);
    buf0_ready_flag <= 1'b1;
    wr(OFF_IRQ_CONTROL, 8'h00);
    rd(OFF_IRQ_CONTROL, 8'h11);
    buf0_ready_flag <= 1'b0;
    // a write without the low byte lane must leave the register alone
    wb_sel_i <= 4'h0;
    bus(OFF_IRQ_CONTROL, 1'b1, 8'hff);
    wb_sel_i <= 4'h1;
    rd(OFF_IRQ_CONTROL, 8'h01);
    $display("register access test done");
    wr(OFF_RX_CONTROL, 8'h68);
    for (int i = 0; i < 4; i++) begin
      rx(8'h10 + 8'(i), 1'b0, 1'b0, 1);
      u_rx_engine_model.idle();
      rd(OFF_BUF3_STATUS, 8'hc1 | {2'b00, cnt, 4'h0});
      rd(OFF_IRQ_CONTROL, irqc);
    end
    rd(OFF_IRQ_CONTROL, 8'he1);
    rd(OFF_RX_BUF3, 8'h13);
    for (int i = 0; i < 4; i++) rx(8'h20 + 8'(i), i == 3, 1'b0, 0);
    u_rx_engine_model.idle();
    rd(OFF_BUF3_STATUS, 8'hc5);
    for (int i = 0; i < 4; i++) rx(8'h30 + 8'(i), 1'b0, 1'b0, 2);
    u_rx_engine_model.idle();
    rd(OFF_BUF3_STATUS, 8'hc7);
    rd(OFF_RX_BUF3, 8'h33);
    wr(OFF_RX_CONTROL, 8'h69);
    for (int i = 0; i < 4; i++) rx(8'h40 + 8'(i), 1'b0, i == 3, 1);
    u_rx_engine_model.idle();
    rd(OFF_BUF3_STATUS, 8'hcf);
    wr(OFF_RX_CONTROL, 8'h6d);
    rx(8'h56, 1'b0, 1'b1, 1);
    rx(8'h55, 1'b0, 1'b0, 1);
    u_rx_engine_model.idle();
    rd(OFF_BUF3_STATUS, 8'hcf | {2'b00, cnt, 4'h0});
    wr(OFF_BUF3_STATUS, 8'h00);
    rd(OFF_BUF3_STATUS, 8'hc1 | {2'b00, cnt, 4'h0});
    $display("ring receive test done");
    for (int b = 1; b < 4; b++) begin
      wr(OFF_IRQ_CONTROL, 8'h10 << b);
      check({7'h0, rx_irq}, 8'h00);
      wr(OFF_IRQ_CONTROL, (8'h10 << b) | (8'h01 << b));
      check({7'h0, rx_irq}, 8'h01);
      wr(OFF_IRQ_CONTROL, (8'h10 << b) | (8'h01 << (b % 3 + 1)));
      check({7'h0, rx_irq}, 8'h00);
    end
    wr(OFF_IRQ_CONTROL, 8'h00);
    buf0_ready_flag <= 1'b1;
    buf0_ready_irq_enable <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check({7'h0, rx_irq}, 8'h01);
    {buf0_ready_flag, buf0_ready_irq_enable} <= 2'b00;
    wr(OFF_IRQ_CONTROL, 8'h22);
    wr(OFF_RX_CONTROL, 8'h60);
    check({7'h0, rx_irq}, 8'h00);
    rx(8'h77, 1'b0, 1'b0, 1);
    u_rx_engine_model.idle();
    rd(OFF_BUF3_STATUS, 8'hc1);
    $display("interrupt test done");
    for (int k = 0; k < 2; k++) begin
      wr(OFF_RX_CONTROL, 8'h68);
      rx(8'h01, 1'b0, 1'b0, 1);
      u_rx_engine_model.idle();
      wr(OFF_IRQ_CONTROL, 8'hee);
      if (k == 0) soft_reset <= 1'b1;
      else rst_b <= 1'b0;
      @(posedge sys_clk);
      {soft_reset, rst_b} <= 2'b01;
      @(posedge sys_clk);
      check({7'h0, rx_irq}, 8'h00);
      rd(OFF_BUF3_STATUS, 8'hc1);
      rd(OFF_IRQ_CONTROL, 8'h01);
      rd(OFF_RX_CONTROL, 8'h00);
    end
    $display("reset sources test done");
    summarize();
  end
endmodule : serial_rx_ring_status_irq_bench
`default_nettype wire

/* File: test/serial_rx_ring_status_irq_monitor.sv */
// port assertions for the receive ring status block
// assumes a single sys_clk domain; attached by bind below
`timescale 1ns/1ns
`default_nettype none
module rx_ring_monitor
  import rx_ring_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic soft_reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [rx_ring_pkg::DATA_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rx_done,
  input wire rx_ring_pkg::rx_frame_type rx_frame,
  input wire logic buf0_ready_flag,
  input wire logic buf0_ready_irq_enable,
  input wire logic [7:0] receive_control_reg,
  input wire logic [1:0] next_buffer_index,
  input wire logic buf0_fill_strobe,
  input wire logic rx_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic taken;
  logic ring;
  assign ring = receive_control_reg[RING_SEL_BIT];
  assign taken = rx_done && !soft_reset && !(receive_control_reg[MP_MODE_BIT]
      && receive_control_reg[ADDR_SEL_BIT]
      && !rx_frame.frame_address_marker_bit);

  // ==========================================================================
  // bus handshake
  sequence s_req;
    $rose(wb_cyc_i && wb_stb_i);
  endsequence
  sequence s_answer;
    !wb_ack_o ##1 wb_ack_o;
  endsequence
  property p_ack_timing;
    s_req |-> ##1 s_answer;
  endproperty
  a_ack_timing: assert property (p_ack_timing) else $error("late ack");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
  property p_dat_upper;
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
  endproperty
  a_dat_upper: assert property (p_dat_upper) else $error("upper data");

  // ==========================================================================
  // buffer counter and requests
  property p_count_step;
    taken && ring |=> next_buffer_index == $past(next_buffer_index) + 2'h1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("step");
  property p_count_hold;
    !rx_done && !soft_reset && ring |=> !ring || $stable(next_buffer_index);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("moved");
  property p_count_off;
    !ring |=> next_buffer_index == 2'b00;
  endproperty
  a_count_off: assert property (p_count_off) else $error("off");
  property p_fill_zero;
    taken && next_buffer_index == 2'b00 |=> buf0_fill_strobe;
  endproperty
  a_fill_zero: assert property (p_fill_zero) else $error("no fill");
  property p_fill_cause;
    buf0_fill_strobe |-> $past(rx_done);
  endproperty
  a_fill_cause: assert property (p_fill_cause) else $error("fill");
  property p_irq_zero;
    buf0_ready_flag && buf0_ready_irq_enable && !soft_reset |=> rx_irq;
  endproperty
  a_irq_zero: assert property (p_irq_zero) else $error("no irq");
  property p_soft_clear;
    soft_reset |=> receive_control_reg == 8'h00 && next_buffer_index == 2'b00;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("reset");
  property p_soft_irq;
    soft_reset |=> !rx_irq && !buf0_fill_strobe;
  endproperty
  a_soft_irq: assert property (p_soft_irq) else $error("irq kept");
endmodule : rx_ring_monitor

bind serial_rx_ring_status_irq rx_ring_monitor u_rx_ring_monitor (
  .sys_clk(sys_clk), .rst_b(rst_b), .soft_reset(soft_reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rx_done(rx_done), .rx_frame(rx_frame),
  .buf0_ready_flag(buf0_ready_flag),
  .buf0_ready_irq_enable(buf0_ready_irq_enable),
  .receive_control_reg(receive_control_reg),
  .next_buffer_index(next_buffer_index),
  .buf0_fill_strobe(buf0_fill_strobe), .rx_irq(rx_irq)
);
`default_nettype wire
